// file: inc/gpdc_pkg.sv
// gpdc_pkg: constants and types for the dual gpio port drive control block
// assumes an 8-bit register port on the cpu clock
package gpdc_pkg;
    localparam int          GPDC_PORT_W     = 8;
    localparam int          GPDC_ADDR_W     = 8;
    localparam logic [7:0]  OFF_P0_DATA     = 8'h00;
    localparam logic [7:0]  OFF_P1_DATA     = 8'h01;
    localparam logic [7:0]  OFF_P0_SEL_LO   = 8'h0a;
    localparam logic [7:0]  OFF_P0_SEL_HI   = 8'h0b;
    localparam logic [7:0]  OFF_P1_SEL_LO   = 8'h0c;
    localparam logic [7:0]  OFF_P1_SEL_HI   = 8'h0d;
    localparam logic [7:0]  OFF_P0_INT_STAT = 8'h20;
    localparam logic [7:0]  OFF_P1_INT_STAT = 8'h21;
    localparam logic [7:0]  OFF_P0_INT_CLR  = 8'h22;
    localparam logic [7:0]  OFF_P1_INT_CLR  = 8'h23;
    localparam logic [7:0]  OFF_P0_INT_EN   = 8'h24;
    localparam logic [7:0]  OFF_P1_INT_EN   = 8'h25;
    localparam logic [7:0]  RST_REG         = 8'h00;
    localparam int          P1_WIDTH_SMALL  = 2;
    localparam int          P1_WIDTH_FULL   = 8;

    typedef enum logic [1:0] {
        SINK_NONE = 2'b00,
        SINK_LOW  = 2'b01,
        SINK_MED  = 2'b10,
        SINK_HIGH = 2'b11
    } gpdc_sink_type;

    // per-pin analog pad controls
    typedef struct packed {
        logic          pullup_resistor_switch;
        logic          sink_transistor;
        logic          source_transistor;
        gpdc_sink_type sink_strength;
        logic          ttl_threshold;
    } gpdc_pin_ctrl_type;

    localparam gpdc_pin_ctrl_type PIN_CTRL_RST = '{1'b0, 1'b0, 1'b0,
                                                   SINK_NONE, 1'b0};
endpackage

// file: hdl/gpdc_gpio.sv
// gpdc_gpio: two gpio ports with data, drive select and pin-change irq
// assumes a single-cycle register port and pads outside that resolve
// the wire from pad_out, pad_oe and the pull-up switch
//
// Notes on behaviour
// - first port has eight pins, second port two or eight by parameter.
// - every port bit can be enabled as an interrupt source.
// - data writes store outgoing values, data reads return pad levels.
// - each pin is decoded from its own data bit and two select bits.
// - reset clears data and select registers, leaving all pins hi-z.
// - both select bits low turn pull-up, sink and source off.
// - hi set, lo clear, data low gives the weak sink only.
// - hi clear, lo set, data low gives the medium sink only.
// - both select bits set with data low give the strongest sink only.
// - lo set with data high turns on only the source, driving high.
// - hi set, lo clear, data high enables only the pull-up resistor.
// - ttl threshold only for data high with both select bits low.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module gpdc_gpio
    import gpdc_pkg::*;
#(
    parameter int P1_WIDTH = gpdc_pkg::P1_WIDTH_FULL
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic [gpdc_pkg::GPDC_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    output logic                               irq,
    input  wire logic [7:0]                    first_port_pins_in,
    output logic      [7:0]                    first_port_pins_out,
    output logic      [7:0]                    first_port_pins_oe,
    output gpdc_pkg::gpdc_pin_ctrl_type [7:0]  first_port_ctrl,
    input  wire logic [7:0]                    second_port_pins_in,
    output logic      [7:0]                    second_port_pins_out,
    output logic      [7:0]                    second_port_pins_oe,
    output gpdc_pkg::gpdc_pin_ctrl_type [7:0]  second_port_ctrl
);
    import gpdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // second port width
    localparam logic [7:0] P1_MASK = 8'(({8'h00, 8'hff} >> (8 - P1_WIDTH))
                                         & 16'h00ff);

    function automatic gpdc_pin_ctrl_type pin_decode(input logic d,
                                                     input logic hi,
                                                     input logic lo);
        gpdc_pin_ctrl_type c;
        c = PIN_CTRL_RST;
        c.pullup_resistor_switch = hi & ~lo & d;
        c.sink_transistor        = (hi | lo) & ~d;
        c.source_transistor      = lo & d;
        c.ttl_threshold          = d & ~hi & ~lo;
        if (!d) begin
            c.sink_strength = gpdc_sink_type'({lo, hi});
        end
        return c;
    endfunction

    logic [7:0] p0_data_q, p1_data_q;
    logic [7:0] p0_lo_q, p0_hi_q, p1_lo_q, p1_hi_q;
    logic [7:0] p0_sync1_q, p0_sync2_q, p0_prev_q;
    logic [7:0] p1_sync1_q, p1_sync2_q, p1_prev_q;
    logic [7:0] p0_stat_q, p1_stat_q, p0_en_q, p1_en_q;
    logic [7:0] p0_evt, p1_evt;
    logic [7:0] rdata_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // data registers store outgoing values
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_data_q <= RST_REG;
            p1_data_q <= RST_REG;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFF_P0_DATA)) begin
                p0_data_q <= reg_wdata;
            end
            if (hit(reg_addr, OFF_P1_DATA)) begin
                p1_data_q <= reg_wdata & P1_MASK;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_lo_q <= RST_REG;
            p0_hi_q <= RST_REG;
            p1_lo_q <= RST_REG;
            p1_hi_q <= RST_REG;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFF_P0_SEL_LO)) begin
                p0_lo_q <= reg_wdata;
            end
            if (hit(reg_addr, OFF_P0_SEL_HI)) begin
                p0_hi_q <= reg_wdata;
            end
            if (hit(reg_addr, OFF_P1_SEL_LO)) begin
                p1_lo_q <= reg_wdata & P1_MASK;
            end
            if (hit(reg_addr, OFF_P1_SEL_HI)) begin
                p1_hi_q <= reg_wdata & P1_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad controls registered so outputs come straight from flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_port_ctrl  <= {8{PIN_CTRL_RST}};
            second_port_ctrl <= {8{PIN_CTRL_RST}};
        end else begin
            for (int i = 0; i < 8; i++) begin
                first_port_ctrl[i]  <= pin_decode(p0_data_q[i], p0_hi_q[i],
                                                  p0_lo_q[i]);
                second_port_ctrl[i] <= pin_decode(p1_data_q[i], p1_hi_q[i],
                                                  p1_lo_q[i]);
            end
        end
    end

    // sink pulls low, source drives high, otherwise released
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            first_port_pins_oe[i]   = first_port_ctrl[i].sink_transistor |
                                      first_port_ctrl[i].source_transistor;
            first_port_pins_out[i]  = first_port_ctrl[i].source_transistor;
            second_port_pins_oe[i]  = second_port_ctrl[i].sink_transistor |
                                      second_port_ctrl[i].source_transistor;
            second_port_pins_out[i] = second_port_ctrl[i].source_transistor;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad synchronisers; prev stage feeds edge detect only
    // unused upper pins are masked only after the second stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_sync1_q <= RST_REG;
            p0_sync2_q <= RST_REG;
            p0_prev_q  <= RST_REG;
            p1_sync1_q <= RST_REG;
            p1_sync2_q <= RST_REG;
            p1_prev_q  <= RST_REG;
        end else begin
            p0_sync1_q <= first_port_pins_in;
            p0_sync2_q <= p0_sync1_q;
            p0_prev_q  <= p0_sync2_q;
            p1_sync1_q <= second_port_pins_in;
            p1_sync2_q <= p1_sync1_q;
            p1_prev_q  <= p1_sync2_q;
        end
    end

    assign p0_evt = p0_sync2_q ^ p0_prev_q;
    assign p1_evt = (p1_sync2_q ^ p1_prev_q) & P1_MASK;

    ////////////////////////////////////////////////////////////////////////
    // pin-change status, set wins over a same-cycle clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_stat_q <= RST_REG;
            p1_stat_q <= RST_REG;
        end else begin
            p0_stat_q <= (p0_stat_q & ~((reg_wr &&
                          hit(reg_addr, OFF_P0_INT_CLR)) ? reg_wdata : 8'h00))
                         | p0_evt;
            p1_stat_q <= (p1_stat_q & ~((reg_wr &&
                          hit(reg_addr, OFF_P1_INT_CLR)) ? reg_wdata : 8'h00))
                         | p1_evt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0_en_q <= RST_REG;
            p1_en_q <= RST_REG;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFF_P0_INT_EN)) begin
                p0_en_q <= reg_wdata;
            end
            if (hit(reg_addr, OFF_P1_INT_EN)) begin
                p1_en_q <= reg_wdata & P1_MASK;
            end
        end
    end

    assign irq = |(p0_stat_q & p0_en_q) | |(p1_stat_q & p1_en_q);

    ////////////////////////////////////////////////////////////////////////
    // data reads give pad levels; select regs read as zero
    always_comb begin
        case (reg_addr)
            OFF_P0_DATA:     rdata_d = p0_sync2_q;
            OFF_P1_DATA:     rdata_d = p1_sync2_q & P1_MASK;
            OFF_P0_INT_STAT: rdata_d = p0_stat_q;
            OFF_P1_INT_STAT: rdata_d = p1_stat_q;
            OFF_P0_INT_EN:   rdata_d = p0_en_q;
            OFF_P1_INT_EN:   rdata_d = p1_en_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= RST_REG;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_read_pad;
        @(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == OFF_P0_DATA ##1 1'b1 |->
            reg_rdata == $past(p0_sync2_q);
    endproperty
    a_read_pad: assert property (p_read_pad)
        else $error("port data read not from pads");

    property p_write_store;
        @(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == OFF_P0_DATA |=> p0_data_q == $past(reg_wdata);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("port data write lost");

    property p_hiz;
        @(posedge mclk) disable iff (!rst_n)
        (p0_lo_q[0] == 1'b0 && p0_hi_q[0] == 1'b0) |=>
            !first_port_ctrl[0].sink_transistor &&
            !first_port_ctrl[0].source_transistor &&
            !first_port_ctrl[0].pullup_resistor_switch &&
            !first_port_pins_oe[0];
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("pin driven with both select bits low");

    property p_weak_sink;
        @(posedge mclk) disable iff (!rst_n)
        (p0_hi_q[1] && !p0_lo_q[1] && !p0_data_q[1]) |=>
            first_port_ctrl[1].sink_strength == SINK_LOW &&
            first_port_pins_oe[1] && !first_port_pins_out[1];
    endproperty
    a_weak_sink: assert property (p_weak_sink)
        else $error("weak sink not selected");

    property p_med_sink;
        @(posedge mclk) disable iff (!rst_n)
        (!p0_hi_q[2] && p0_lo_q[2] && !p0_data_q[2]) |=>
            first_port_ctrl[2].sink_strength == SINK_MED &&
            first_port_ctrl[2].sink_transistor;
    endproperty
    a_med_sink: assert property (p_med_sink)
        else $error("medium sink not selected");

    property p_high_sink;
        @(posedge mclk) disable iff (!rst_n)
        (p1_hi_q[0] && p1_lo_q[0] && !p1_data_q[0]) |=>
            second_port_ctrl[0].sink_strength == SINK_HIGH &&
            second_port_ctrl[0].sink_transistor;
    endproperty
    a_high_sink: assert property (p_high_sink)
        else $error("strong sink not selected");

    property p_source;
        @(posedge mclk) disable iff (!rst_n)
        (p0_lo_q[3] && p0_data_q[3]) |=>
            first_port_pins_oe[3] && first_port_pins_out[3] &&
            !first_port_ctrl[3].sink_transistor;
    endproperty
    a_source: assert property (p_source)
        else $error("source drive not selected");

    property p_pullup;
        @(posedge mclk) disable iff (!rst_n)
        (p0_hi_q[4] && !p0_lo_q[4] && p0_data_q[4]) |=>
            first_port_ctrl[4].pullup_resistor_switch && !first_port_pins_oe[4];
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up not selected");

    property p_ttl;
        @(posedge mclk) disable iff (!rst_n)
        ##1 first_port_ctrl[5].ttl_threshold ==
            $past(p0_data_q[5] && !p0_hi_q[5] && !p0_lo_q[5]);
    endproperty
    a_ttl: assert property (p_ttl)
        else $error("threshold select wrong");

    property p_exclusive;
        @(posedge mclk) disable iff (!rst_n)
        $onehot0({second_port_ctrl[1].sink_transistor,
                  second_port_ctrl[1].source_transistor,
                  second_port_ctrl[1].pullup_resistor_switch});
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("pad controls overlap");

    property p_irq;
        @(posedge mclk) disable iff (!rst_n)
        (p0_evt[0] && p0_en_q[0]) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled pin change gave no interrupt");

    property p_set_wins;
        @(posedge mclk) disable iff (!rst_n)
        p0_evt[0] |=> p0_stat_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("pin change not recorded");

    property p_clear;
        @(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == OFF_P0_INT_CLR && reg_wdata[0] &&
            !p0_evt[0] |=> !p0_stat_q[0];
    endproperty
    a_clear: assert property (p_clear)
        else $error("status bit survived its clear");

    property p_rdata_idle;
        @(posedge mclk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

    property p_sel_read_zero;
        @(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr >= OFF_P0_SEL_LO && reg_addr <= OFF_P1_SEL_HI
            |=> reg_rdata == 8'h00;
    endproperty
    a_sel_read_zero: assert property (p_sel_read_zero)
        else $error("drive select register readable");

    property p_ctrl_hold;
        @(posedge mclk) disable iff (!rst_n)
        !reg_wr |-> ##2 $stable(first_port_ctrl) &&
            $stable(second_port_ctrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("pad controls moved without a write");

    // no disable: this one watches the cleared state while reset is held
    property p_reset_clear;
        @(posedge mclk)
        !rst_n ##1 !rst_n |-> (p0_data_q | p1_data_q | p0_lo_q | p0_hi_q |
            p1_lo_q | p1_hi_q) == 8'h00 &&
            (first_port_pins_oe | second_port_pins_oe) == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("registers or drivers live during reset");

    c_sink: cover property (@(posedge mclk) disable iff (!rst_n)
        first_port_ctrl[0].sink_strength == SINK_HIGH);
    c_irq: cover property (@(posedge mclk) disable iff (!rst_n) irq);
    c_read: cover property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == OFF_P1_DATA);
    c_pullup: cover property (@(posedge mclk) disable iff (!rst_n)
        first_port_ctrl[4].pullup_resistor_switch);
    c_source: cover property (@(posedge mclk) disable iff (!rst_n)
        second_port_pins_oe[7] && second_port_pins_out[7]);
endmodule // gpdc_gpio

// file: tb/gpdc_board.sv
// gpdc_board: board circuitry on the eight pins of one port
// assumes pad drive lines and pad controls straight from the gpio block
`timescale 1ns/1ps
module gpdc_board
    import gpdc_pkg::*;
(
    input  wire logic [7:0]                        pins_out,
    input  wire logic [7:0]                        pins_oe,
    input  wire gpdc_pkg::gpdc_pin_ctrl_type [7:0] ctrl,
    input  wire logic [7:0]                        ext_val,
    input  wire logic [7:0]                        ext_en,
    output logic      [7:0]                        pins_in
);
    // a floating pin flips, so a stale level never passes for a read
    always @(pins_out or pins_oe or ctrl or ext_val or ext_en) begin
        for (int k = 0; k < 8; k++) begin
            if (pins_oe[k])
                pins_in[k] = pins_out[k];
            else if (ext_en[k])
                pins_in[k] = ext_val[k];
            else if (ctrl[k].pullup_resistor_switch)
                pins_in[k] = 1'b1;
            else
                pins_in[k] = ~pins_in[k];
        end
    end
endmodule // gpdc_board

// file: tb/tb.sv
// tb: self-checking bench for the dual gpio port block
// assumes the register port, board models on both ports, one clock
`timescale 1ns/1ps
module tb;
    import gpdc_pkg::*;
    logic                    mclk, rst_n, reg_wr, reg_rd, irq;
    logic [7:0]              reg_addr, reg_wdata, reg_rdata, v;
    logic [7:0]              po [2], pe [2], pi [2], ev [2], ee [2];
    logic [7:0]              dat [2], slo [2], shi [2], eo, eu;
    gpdc_pin_ctrl_type [7:0] cc [2];
    int                      mismatches, checks, seed, p, i, n, q, j;

    gpdc_gpio #(.P1_WIDTH(8)) gpdc_gpio_i (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq),
        .first_port_pins_in(pi[0]), .first_port_pins_out(po[0]),
        .first_port_pins_oe(pe[0]), .first_port_ctrl(cc[0]),
        .second_port_pins_in(pi[1]), .second_port_pins_out(po[1]),
        .second_port_pins_oe(pe[1]), .second_port_ctrl(cc[1]));
    gpdc_board board0_i (.pins_out(po[0]), .pins_oe(pe[0]), .ctrl(cc[0]),
        .ext_val(ev[0]), .ext_en(ee[0]), .pins_in(pi[0]));
    gpdc_board board1_i (.pins_out(po[1]), .pins_oe(pe[1]), .ctrl(cc[1]),
        .ext_val(ev[1]), .ext_en(ee[1]), .pins_in(pi[1]));

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task summarize();
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic gpdc_pin_ctrl_type exp_ctrl(logic d, hi, lo);
        gpdc_pin_ctrl_type e;
        e = PIN_CTRL_RST;
        if (lo && d)
            e.source_transistor = 1'b1;
        else if (!d && (hi || lo)) begin
            e.sink_transistor = 1'b1;
            if (!lo)
                e.sink_strength = SINK_LOW;
            else if (hi)
                e.sink_strength = SINK_HIGH;
            else
                e.sink_strength = SINK_MED;
        end else if (hi && d)
            e.pullup_resistor_switch = 1'b1;
        e.ttl_threshold = d && !hi && !lo;
        return e;
    endfunction

    task apply();
        wr(OFF_P0_DATA, dat[0]);
        wr(OFF_P1_DATA, dat[1]);
        wr(OFF_P0_SEL_LO, slo[0]);
        wr(OFF_P0_SEL_HI, shi[0]);
        wr(OFF_P1_SEL_LO, slo[1]);
        wr(OFF_P1_SEL_HI, shi[1]);
    endtask

    // pad controls per pin, then a data read of live pad levels
    task check_pins();
        gpdc_pin_ctrl_type e;
        repeat (2) @(posedge mclk);
        #1;
        for (q = 0; q < 2; q++) begin
            for (j = 0; j < 8; j++) begin
                e     = exp_ctrl(dat[q][j], shi[q][j], slo[q][j]);
                eo[j] = e.sink_transistor | e.source_transistor;
                eu[j] = e.source_transistor;
                chk({2'b00, cc[q][j]}, {2'b00, e});
                chk({6'b0, pe[q][j], po[q][j]}, {6'b0, eo[j], eu[j]});
            end
            // board drives only where the block does not
            @(posedge mclk);
            ee[q] <= ~eo;
            ev[q] <= 8'($random(seed));
            repeat (4) @(posedge mclk);
            rd(q ? OFF_P1_DATA : OFF_P0_DATA, v);
            chk(v, (eo & eu) | (~eo & ev[q]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h15cf;
        mclk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        for (p = 0; p < 2; p++) begin
            ev[p] = 8'h00;
            ee[p] = 8'hff;
            dat[p] = 8'h00;
            slo[p] = 8'h00;
            shi[p] = 8'h00;
        end
        repeat (16) @(posedge mclk);
        chk(pe[0] | pe[1] | po[0] | po[1], 8'h00);
        rst_n <= 1'b1;
        check_pins();
        // every data and select combination on all pins; both select bits low is hi-z
        for (n = 0; n < 8; n++) begin
            for (p = 0; p < 2; p++) begin
                dat[p] = {8{n[2]}};
                shi[p] = {8{n[1]}};
                slo[p] = {8{n[0]}};
            end
            apply();
            check_pins();
        end
        for (n = 0; n < 40; n++) begin
            for (p = 0; p < 2; p++) begin
                dat[p] = 8'($random(seed));
                shi[p] = 8'($random(seed));
                slo[p] = 8'($random(seed));
            end
            apply();
            check_pins();
        end
        // reset in mid-run with live settings must clear everything
        wr(OFF_P1_INT_EN, 8'h5a);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(pe[0] | pe[1] | po[0] | po[1], 8'h00);
        rst_n <= 1'b1;
        for (p = 0; p < 2; p++) begin
            dat[p] = 8'h00;
            shi[p] = 8'h00;
            slo[p] = 8'h00;
        end
        rd(OFF_P1_INT_EN, v);
        chk(v, 8'h00);
        check_pins();
        for (n = 8'h0a; n <= 8'h0d; n++) begin
            rd(8'(n), v);
            chk(v, 8'h00);
        end
        rd(8'h30, v);
        chk(v, 8'h00);
        wr(8'h30, 8'hff);
        check_pins();
        // interrupts from hi-z pins toggled by the board
        for (p = 0; p < 2; p++) begin
            dat[p] = 8'h00;
            shi[p] = 8'h00;
            slo[p] = 8'h00;
        end
        apply();
        check_pins();
        wr(OFF_P0_INT_CLR, 8'hff);
        wr(OFF_P1_INT_CLR, 8'hff);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 8; i++) begin
                wr(8'(OFF_P0_INT_EN + p), 8'h01 << i);
                rd(8'(OFF_P0_INT_EN + p), v);
                chk(v, 8'h01 << i);
                @(posedge mclk);
                ev[p] <= ev[p] ^ (8'h01 << i);
                repeat (5) @(posedge mclk);
                #1 chk({7'b0, irq}, 8'h01);
                rd(8'(OFF_P0_INT_STAT + p), v);
                chk(v, 8'h01 << i);
                wr(8'(OFF_P0_INT_CLR + p), 8'h01 << i);
                @(posedge mclk);
                #1 chk({7'b0, irq}, 8'h00);
                @(posedge mclk);
                ev[p] <= ev[p] ^ (8'h01 << (i ^ 1));
                repeat (5) @(posedge mclk);
                #1 chk({7'b0, irq}, 8'h00);
                rd(8'(OFF_P0_INT_STAT + p), v);
                chk(v, 8'h01 << (i ^ 1));
                wr(8'(OFF_P0_INT_CLR + p), 8'hff);
            end
            wr(8'(OFF_P0_INT_EN + p), 8'h00);
        end
        summarize();
    end

    // hang guard, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        summarize();
    end
endmodule // tb
